// >>> design/fesc_pkg.sv
/*
 Constants for the flash erase and security command sequencer: command codes,
 slot indices, array operation codes, field layouts and fixed addresses.
 Assumes a single clock domain and an array engine that answers each operation.
*/
package fesc_pkg;
   // ----------------------------------------------------------------
   // Command codes
   // ----------------------------------------------------------------
   localparam logic [7:0]  CMD_PROGRAM_ONCE = 8'h07;
   localparam logic [7:0]  CMD_ERASE_ALL    = 8'h08;
   localparam logic [7:0]  CMD_ERASE_BLOCK  = 8'h09;
   localparam logic [7:0]  CMD_ERASE_SECTOR = 8'h0a;
   localparam logic [7:0]  CMD_UNSECURE     = 8'h0b;
   localparam logic [7:0]  CMD_VERIFY_KEY   = 8'h0c;

   // ----------------------------------------------------------------
   // Slot indices at launch and slot layout
   // ----------------------------------------------------------------
   localparam logic [2:0]  IDX_ERASE_ALL    = 3'h0;
   localparam logic [2:0]  IDX_UNSECURE     = 3'h0;
   localparam logic [2:0]  IDX_ERASE_BLOCK  = 3'h1;
   localparam logic [2:0]  IDX_ERASE_SECTOR = 3'h1;
   localparam logic [2:0]  IDX_VERIFY_KEY   = 3'h4;
   localparam logic [2:0]  IDX_PROGRAM_ONCE = 3'h5;
   localparam int          SLOT_W           = 16;
   localparam int          SLOT_N           = 6;
   localparam int          SLOT_CODE_LSB    = 8;
   localparam logic [15:0] ONCE_INDEX_MAX   = 16'h0007;

   // ----------------------------------------------------------------
   // Addresses and field values
   // ----------------------------------------------------------------
   localparam int          ADDR_W           = 18;
   localparam logic [17:0] KEY_BASE_ADDR    = 18'h3ff00;
   localparam logic [63:0] PHRASE_ALL_ONES  = 64'hffff_ffff_ffff_ffff;
   localparam logic [1:0]  KEY_ENABLED      = 2'h2;
   localparam logic [2:0]  PHRASE_ALIGN_OK  = 3'h0;

   // ----------------------------------------------------------------
   // Array operation codes
   // ----------------------------------------------------------------
   localparam logic [3:0]  OP_NONE          = 4'h0;
   localparam logic [3:0]  OP_ONCE_READ     = 4'h1;
   localparam logic [3:0]  OP_ONCE_PROGRAM  = 4'h2;
   localparam logic [3:0]  OP_ONCE_VERIFY   = 4'h3;
   localparam logic [3:0]  OP_ERASE_ALL     = 4'h4;
   localparam logic [3:0]  OP_ERASE_BLOCK   = 4'h5;
   localparam logic [3:0]  OP_ERASE_SECTOR  = 4'h6;
   localparam logic [3:0]  OP_VERIFY_ALL    = 4'h7;
   localparam logic [3:0]  OP_VERIFY_BLOCK  = 4'h8;
   localparam logic [3:0]  OP_VERIFY_SECTOR = 4'h9;
   localparam logic [3:0]  OP_KEY_READ      = 4'ha;

   typedef enum logic [3:0] {
      ST_IDLE, ST_CHECK, ST_BLANK, ST_PROG, ST_VERIFY, ST_ERASE, ST_EVER, ST_KEY, ST_DONE
   } fesc_state_t;
endpackage

// >>> design/fesc_sequencer.sv
/*
 Command sequencer for Program Once, Erase All Blocks, Erase Flash Block,
 Erase Program-Flash Sector, Unsecure Flash and Verify Backdoor Access Key.
 Assumes launch, parameters, protection, mode and key-enable inputs come from
 logic on clk_sys_i, and an array engine that answers each request with done.
*/
// What this block does
// - Program Once checks blank, programs, reads back; complete flag low throughout.
// - Program Once phrase index in slot 1 must be 0..7, data slots 2..5.
// - Program Once errors on slot index not 5 or phrase already programmed.
// - A phrase left at all ones counts as unprogrammed and may be reprogrammed.
// - Program-flash reads return invalid data during Program Once.
// - Verify errors set verify bit 1; non-correctable ones set verify bit 0.
// - Erase All needs index 0, erases both arrays, verifies, releases security on success.
// - Erase All and Unsecure flag protection violation if any region is protected.
// - Erase Block needs index 1, address in slots 0 and 1, erases then verifies.
// - Erase Block errors on bad upper bits or misalignment; protected block flags violation.
// - Sector erase needs index 1, erases the addressed sector and verifies.
// - Sector erase errors on address bits 2..0 nonzero or bad upper bits; protection flagged.
// - Unsecure needs index 0, erases, verifies, releases security only on success.
// - Key verify errors and ends without compare unless key-enable field is 10.
// - Key verify takes keys in slots 1..4, needs index 4.
// - All four keys must match stored key from base address to release security.
// - A key mismatch errors and locks out key verify until reset.
// - Commands start when complete flag clears; it sets only when fully done.
// - Commands unavailable in current mode, except key verify, raise the access error flag.
`timescale 1ns/1ps
`default_nettype none
module fesc_sequencer #(
   parameter logic [1:0] PFLASH_HI_CODE = 2'h3,
   parameter logic [1:0] DFLASH_HI_CODE = 2'h0
) (
   input  wire logic                    clk_sys_i,
   input  wire logic                    rst_i,
   input  wire logic                    launch_i,
   input  wire logic [7:0]              command_code_i,
   input  wire logic [2:0]              command_slot_index_i,
   input  wire logic [95:0]             command_parameter_words_i,
   input  wire logic                    clear_errors_i,
   input  wire logic                    command_available_i,
   input  wire logic                    any_area_protected_i,
   input  wire logic                    block_protected_i,
   input  wire logic                    sector_protected_i,
   input  wire logic [1:0]              backdoor_key_enable_field_i,
   input  wire logic                    array_done_i,
   input  wire logic                    array_fail_i,
   input  wire logic                    array_noncorr_i,
   input  wire logic [63:0]             array_rdata_i,
   output logic                         command_complete_flag_o,
   output logic                         access_error_flag_o,
   output logic                         protection_violation_flag_o,
   output logic                         verify_status_bit1_o,
   output logic                         verify_status_bit0_o,
   output logic                         security_release_o,
   output logic                         key_lockout_o,
   output logic                         pflash_read_invalid_o,
   output logic                         array_req_o,
   output logic [3:0]                   array_op_o,
   output logic [17:0]                  array_addr_o,
   output logic [63:0]                  array_wdata_o
);
   // ----------------------------------------------------------------
   // State and latched command
   // ----------------------------------------------------------------
   fesc_pkg::fesc_state_t state_q, state_d;
   logic [7:0]              cmd_q;
   logic [2:0]              idx_q;
   logic [95:0]             words_q;
   logic                    ccf_q, acc_q, fpv_q, mg1_q, mg0_q;
   logic                    rel_q, lock_q, req_q, issued_q, invalid_q;
   logic [3:0]              op_q;
   logic [17:0]             addr_q;
   logic [63:0]             wdata_q;

   // ----------------------------------------------------------------
   // Parameter decode
   // ----------------------------------------------------------------
   wire logic [15:0] slot0     = words_q[0*fesc_pkg::SLOT_W +: fesc_pkg::SLOT_W];
   wire logic [15:0] slot1     = words_q[1*fesc_pkg::SLOT_W +: fesc_pkg::SLOT_W];
   wire logic [63:0] key_words = words_q[1*fesc_pkg::SLOT_W +: 4*fesc_pkg::SLOT_W];
   wire logic [63:0] once_data = words_q[2*fesc_pkg::SLOT_W +: 4*fesc_pkg::SLOT_W];
   wire logic [1:0]  addr_hi   = slot0[1:0];
   wire logic [17:0] gaddr     = {addr_hi, slot1};
   wire logic        is_pf     = (addr_hi == PFLASH_HI_CODE);
   wire logic        is_df     = (addr_hi == DFLASH_HI_CODE);
   wire logic        pf_align  = (slot1[2:0] == fesc_pkg::PHRASE_ALIGN_OK);
   wire logic        df_align  = ~slot1[0];
   wire logic        c_once    = (cmd_q == fesc_pkg::CMD_PROGRAM_ONCE);
   wire logic        c_all     = (cmd_q == fesc_pkg::CMD_ERASE_ALL);
   wire logic        c_blk     = (cmd_q == fesc_pkg::CMD_ERASE_BLOCK);
   wire logic        c_sec     = (cmd_q == fesc_pkg::CMD_ERASE_SECTOR);
   wire logic        c_uns     = (cmd_q == fesc_pkg::CMD_UNSECURE);
   wire logic        c_key     = (cmd_q == fesc_pkg::CMD_VERIFY_KEY);
   wire logic        c_known   = c_once | c_all | c_blk | c_sec | c_uns | c_key;
   wire logic        c_mass    = c_all | c_uns;

   // Access error checks made once, in the check state the cycle after launch
   wire logic err_once  = c_once & ((idx_q != fesc_pkg::IDX_PROGRAM_ONCE)
                          | (slot1 > fesc_pkg::ONCE_INDEX_MAX));
   wire logic err_all   = c_all & (idx_q != fesc_pkg::IDX_ERASE_ALL);
   wire logic err_uns   = c_uns & (idx_q != fesc_pkg::IDX_UNSECURE);
   wire logic err_blk   = c_blk & ((idx_q != fesc_pkg::IDX_ERASE_BLOCK)
                          | ~(is_pf | is_df) | (is_pf & ~pf_align)
                          | (is_df & ~is_pf & ~df_align));
   wire logic err_sec   = c_sec & ((idx_q != fesc_pkg::IDX_ERASE_SECTOR)
                          | ~is_pf | ~pf_align);
   wire logic err_key   = c_key & ((idx_q != fesc_pkg::IDX_VERIFY_KEY)
                          | (backdoor_key_enable_field_i != fesc_pkg::KEY_ENABLED)
                          | lock_q);
   wire logic err_mode  = (c_known & ~c_key) & ~command_available_i;
   wire logic chk_acc   = ~c_known | err_once | err_all | err_uns | err_blk | err_sec | err_key | err_mode;
   wire logic chk_fpv   = (c_mass & any_area_protected_i)
                          | (c_blk & block_protected_i)
                          | (c_sec & sector_protected_i);
   wire logic chk_fail  = chk_acc | chk_fpv;

   wire logic op_state  = (state_q == fesc_pkg::ST_BLANK) | (state_q == fesc_pkg::ST_PROG)
                          | (state_q == fesc_pkg::ST_VERIFY) | (state_q == fesc_pkg::ST_ERASE)
                          | (state_q == fesc_pkg::ST_EVER) | (state_q == fesc_pkg::ST_KEY);
   wire logic op_end    = issued_q & array_done_i;
   wire logic take      = launch_i & ccf_q;
   wire logic once_used = (array_rdata_i != fesc_pkg::PHRASE_ALL_ONES);
   wire logic key_match = (array_rdata_i == key_words);
   wire logic ever_ok   = ~array_fail_i & ~array_noncorr_i;

   // ----------------------------------------------------------------
   // Array operation select
   // ----------------------------------------------------------------
   logic [3:0]  op_d;
   logic [17:0] addr_d;
   always_comb begin
      op_d   = fesc_pkg::OP_NONE;
      addr_d = gaddr;
      case (state_q)
         fesc_pkg::ST_BLANK:  op_d = fesc_pkg::OP_ONCE_READ;
         fesc_pkg::ST_PROG:   op_d = fesc_pkg::OP_ONCE_PROGRAM;
         fesc_pkg::ST_VERIFY: op_d = fesc_pkg::OP_ONCE_VERIFY;
         fesc_pkg::ST_ERASE:  op_d = c_mass ? fesc_pkg::OP_ERASE_ALL
                                    : (c_blk ? fesc_pkg::OP_ERASE_BLOCK : fesc_pkg::OP_ERASE_SECTOR);
         fesc_pkg::ST_EVER:   op_d = c_mass ? fesc_pkg::OP_VERIFY_ALL
                                    : (c_blk ? fesc_pkg::OP_VERIFY_BLOCK : fesc_pkg::OP_VERIFY_SECTOR);
         fesc_pkg::ST_KEY: begin
            op_d   = fesc_pkg::OP_KEY_READ;
            addr_d = fesc_pkg::KEY_BASE_ADDR;
         end
         default:             op_d = fesc_pkg::OP_NONE;
      endcase
      if (c_once) begin
         addr_d = {2'h0, slot1};
      end
   end

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      case (state_q)
         fesc_pkg::ST_IDLE:   if (take) state_d = fesc_pkg::ST_CHECK;
         fesc_pkg::ST_CHECK: begin
            if (chk_fail) state_d = fesc_pkg::ST_DONE;
            else if (c_once) state_d = fesc_pkg::ST_BLANK;
            else if (c_key) state_d = fesc_pkg::ST_KEY;
            else state_d = fesc_pkg::ST_ERASE;
         end
         fesc_pkg::ST_BLANK:  if (op_end) state_d = once_used ? fesc_pkg::ST_DONE : fesc_pkg::ST_PROG;
         fesc_pkg::ST_PROG:   if (op_end) state_d = fesc_pkg::ST_VERIFY;
         fesc_pkg::ST_VERIFY: if (op_end) state_d = fesc_pkg::ST_DONE;
         fesc_pkg::ST_ERASE:  if (op_end) state_d = fesc_pkg::ST_EVER;
         fesc_pkg::ST_EVER:   if (op_end) state_d = fesc_pkg::ST_DONE;
         fesc_pkg::ST_KEY:    if (op_end) state_d = fesc_pkg::ST_DONE;
         fesc_pkg::ST_DONE:   state_d = fesc_pkg::ST_IDLE;
         default:             state_d = fesc_pkg::ST_IDLE;
      endcase
   end

   wire logic acc_set = ((state_q == fesc_pkg::ST_CHECK) & chk_acc)
                        | ((state_q == fesc_pkg::ST_BLANK) & op_end & once_used)
                        | ((state_q == fesc_pkg::ST_KEY) & op_end & ~key_match);
   wire logic fpv_set = (state_q == fesc_pkg::ST_CHECK) & chk_fpv;
   wire logic vfy_end = op_end & ((state_q == fesc_pkg::ST_VERIFY) | (state_q == fesc_pkg::ST_EVER));
   wire logic mg1_set = vfy_end & (array_fail_i | array_noncorr_i);
   wire logic mg0_set = vfy_end & array_noncorr_i;
   wire logic rel_set = (op_end & (state_q == fesc_pkg::ST_EVER) & c_mass & ever_ok)
                        | (op_end & (state_q == fesc_pkg::ST_KEY) & key_match);

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         state_q <= fesc_pkg::ST_IDLE;
         cmd_q   <= 8'h00;
         idx_q   <= 3'h0;
         words_q <= 96'h0;
      end else begin
         state_q <= state_d;
         if (take) begin
            cmd_q   <= command_parameter_words_i[fesc_pkg::SLOT_CODE_LSB +: 8];
            idx_q   <= command_slot_index_i;
            words_q <= command_parameter_words_i;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         ccf_q <= 1'b1;
         acc_q <= 1'b0;
         fpv_q <= 1'b0;
         mg1_q <= 1'b0;
         mg0_q <= 1'b0;
      end else begin
         if (take) ccf_q <= 1'b0;
         else if (state_q == fesc_pkg::ST_DONE) ccf_q <= 1'b1;
         acc_q <= acc_set | (acc_q & ~clear_errors_i);
         fpv_q <= fpv_set | (fpv_q & ~clear_errors_i);
         mg1_q <= mg1_set | (mg1_q & ~take);
         mg0_q <= mg0_set | (mg0_q & ~take);
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         rel_q     <= 1'b0;
         lock_q    <= 1'b0;
         invalid_q <= 1'b0;
      end else begin
         rel_q     <= rel_set;
         if ((state_q == fesc_pkg::ST_KEY) & op_end & ~key_match) lock_q <= 1'b1;
         invalid_q <= c_once & ~take & (state_d != fesc_pkg::ST_IDLE) & (state_d != fesc_pkg::ST_DONE);
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         req_q    <= 1'b0;
         issued_q <= 1'b0;
         op_q     <= fesc_pkg::OP_NONE;
         addr_q   <= 18'h0;
         wdata_q  <= 64'h0;
      end else begin
         req_q <= op_state & ~issued_q;
         if (op_state & ~issued_q) begin
            issued_q <= 1'b1;
            op_q     <= op_d;
            addr_q   <= addr_d;
            wdata_q  <= once_data;
         end else if (op_end) begin
            issued_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign command_complete_flag_o     = ccf_q;
   assign access_error_flag_o         = acc_q;
   assign protection_violation_flag_o = fpv_q;
   assign verify_status_bit1_o        = mg1_q;
   assign verify_status_bit0_o        = mg0_q;
   assign security_release_o          = rel_q;
   assign key_lockout_o               = lock_q;
   assign pflash_read_invalid_o       = invalid_q;
   assign array_req_o                 = req_q;
   assign array_op_o                  = op_q;
   assign array_addr_o                = addr_q;
   assign array_wdata_o               = wdata_q;
endmodule
`default_nettype wire

// >>> tb/fesc_sequencer_monitor.sv
/*
 Checker for the flash erase and security command sequencer port behaviour.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module fesc_sequencer_monitor (
   input wire logic        clk_sys_i,
   input wire logic        rst_i,
   input wire logic        launch_i,
   input wire logic [95:0] command_parameter_words_i,
   input wire logic        command_available_i,
   input wire logic [1:0]  backdoor_key_enable_field_i,
   input wire logic        array_done_i,
   input wire logic        array_fail_i,
   input wire logic        array_noncorr_i,
   input wire logic        command_complete_flag_o,
   input wire logic        access_error_flag_o,
   input wire logic        verify_status_bit1_o,
   input wire logic        verify_status_bit0_o,
   input wire logic        security_release_o,
   input wire logic        key_lockout_o,
   input wire logic        pflash_read_invalid_o,
   input wire logic        array_req_o,
   input wire logic [3:0]  array_op_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   wire       take_w = launch_i && command_complete_flag_o;
   wire [7:0] code_w = command_parameter_words_i[15:8];
   wire       nomode_w = take_w && !command_available_i && code_w != fesc_pkg::CMD_VERIFY_KEY;
   wire       ver_w = array_done_i && (array_op_o == fesc_pkg::OP_VERIFY_ALL ||
              array_op_o == fesc_pkg::OP_VERIFY_BLOCK || array_op_o == fesc_pkg::OP_VERIFY_SECTOR ||
              array_op_o == fesc_pkg::OP_ONCE_VERIFY);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   property p_busy; take_w |=> !command_complete_flag_o; endproperty
   property p_mode; nomode_w |-> ##2 access_error_flag_o ##1 command_complete_flag_o; endproperty
   property p_noarray; nomode_w |-> !array_req_o [*4]; endproperty
   property p_backdoor_key_enable_field;
      take_w && code_w == fesc_pkg::CMD_VERIFY_KEY && backdoor_key_enable_field_i != fesc_pkg::KEY_ENABLED
      |-> ##2 access_error_flag_o ##1 command_complete_flag_o;
   endproperty
   property p_lock; key_lockout_o |=> key_lockout_o; endproperty
   property p_mg1; ver_w && array_fail_i |-> ##[1:2] verify_status_bit1_o; endproperty
   property p_mg0; ver_w && array_noncorr_i |-> ##[1:2] verify_status_bit0_o; endproperty
   property p_rel; security_release_o |-> $past(array_done_i) && !$past(array_fail_i); endproperty
   property p_inv; pflash_read_invalid_o |-> !command_complete_flag_o; endproperty
   property p_idle; command_complete_flag_o |-> !array_req_o; endproperty
   a_busy: assert property (p_busy) else $error("complete flag stayed high after launch");
   a_mode: assert property (p_mode) else $error("mode refusal not flagged in time");
   a_noarray: assert property (p_noarray) else $error("array touched by refused command");
   a_backdoor_key_enable_field: assert property (p_backdoor_key_enable_field) else $error("disabled key verify not refused");
   a_lock: assert property (p_lock) else $error("key lockout dropped without reset");
   a_mg1: assert property (p_mg1) else $error("verify bit 1 not set on verify error");
   a_mg0: assert property (p_mg0) else $error("verify bit 0 not set on hard error");
   a_rel: assert property (p_rel) else $error("security released without good verify");
   a_inv: assert property (p_inv) else $error("read invalid while idle");
   a_idle: assert property (p_idle) else $error("array request while idle");
   c_erase_all: cover property (take_w && code_w == fesc_pkg::CMD_ERASE_ALL);
   c_release: cover property (security_release_o);
   c_locked: cover property (key_lockout_o && take_w);
endmodule
bind fesc_sequencer fesc_sequencer_monitor u_mon (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .launch_i(launch_i),
   .command_parameter_words_i(command_parameter_words_i), .command_available_i(command_available_i),
   .backdoor_key_enable_field_i(backdoor_key_enable_field_i), .array_done_i(array_done_i),
   .array_fail_i(array_fail_i), .array_noncorr_i(array_noncorr_i), .command_complete_flag_o(command_complete_flag_o),
   .access_error_flag_o(access_error_flag_o), .verify_status_bit1_o(verify_status_bit1_o),
   .verify_status_bit0_o(verify_status_bit0_o), .security_release_o(security_release_o),
   .key_lockout_o(key_lockout_o), .pflash_read_invalid_o(pflash_read_invalid_o), .array_req_o(array_req_o),
   .array_op_o(array_op_o));
`default_nettype wire

// >>> tb/tb_fesc_sequencer.sv
/*
 Self-checking bench for the flash erase and security command sequencer.
 Assumes the bench plays host and array engine.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_fesc_sequencer;
   logic        clk = 1'b0, rst = 1'b1, go = 1'b0, clr = 1'b0, avail = 1'b1;
   logic        anyp = 1'b0, blkp = 1'b0, secp = 1'b0, done = 1'b0, fail = 1'b0, nc = 1'b0;
   logic [2:0]  ix = 3'h0;
   logic [95:0] words = 96'h0;
   logic [1:0]  backdoor_key_enable_field = 2'h2;
   logic [63:0] rdata = 64'h0;
   logic        ccf, acc, fpv, mg1, mg0, rel, lock, inv, req;
   logic [3:0]  op;
   logic [17:0] addr;
   logic [63:0] wdata;
   int          err_count = 0, checks_done = 0, cycles = 0, rel_cnt = 0;
   fesc_sequencer dut (.clk_sys_i(clk), .rst_i(rst), .launch_i(go), .command_code_i(words[15:8]),
      .command_slot_index_i(ix), .command_parameter_words_i(words), .clear_errors_i(clr),
      .command_available_i(avail), .any_area_protected_i(anyp), .block_protected_i(blkp),
      .sector_protected_i(secp), .backdoor_key_enable_field_i(backdoor_key_enable_field), .array_done_i(done), .array_fail_i(fail),
      .array_noncorr_i(nc), .array_rdata_i(rdata), .command_complete_flag_o(ccf), .access_error_flag_o(acc),
      .protection_violation_flag_o(fpv), .verify_status_bit1_o(mg1), .verify_status_bit0_o(mg0),
      .security_release_o(rel), .key_lockout_o(lock), .pflash_read_invalid_o(inv), .array_req_o(req),
      .array_op_o(op), .array_addr_o(addr), .array_wdata_o(wdata));
   always #10 clk = ~clk;
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic launch(input logic [95:0] w, input logic [2:0] i);
      @(posedge clk);
      words <= w;
      ix <= i;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
   endtask
   task automatic serve(input logic [3:0] xop, input logic f, input logic n, input logic [63:0] rd);
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (req !== 1'b1 && k < 40);
      chk("array_op", op, xop);
      done <= 1'b1;
      fail <= f;
      nc <= n;
      rdata <= rd;
      @(posedge clk);
      done <= 1'b0;
   endtask
   task automatic finish(input logic a, input logic p, input logic m1, input logic m0);
      int k, nr;
      k = 0;
      nr = 0;
      do begin
         @(posedge clk);
         k++;
         if (req === 1'b1) nr++;
      end while (ccf !== 1'b1 && k < 60);
      chk("complete_flag", ccf, 1'b1);
      chk("access_error", acc, a);
      chk("protection", fpv, p);
      chk("verify_bit1", mg1, m1);
      chk("verify_bit0", mg0, m0);
      chk("late_requests", nr, 0);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic prog_once();
      launch({16'h4444, 16'h3333, 16'h2222, 16'h1111, 16'h0003, 16'h0700}, 3'h5);
      serve(fesc_pkg::OP_ONCE_READ, 1'b0, 1'b0, fesc_pkg::PHRASE_ALL_ONES);
      chk("once_addr", addr, 18'h00003);
      chk("read_invalid", inv, 1'b1);
      serve(fesc_pkg::OP_ONCE_PROGRAM, 1'b0, 1'b0, 64'h0);
      chk("once_data", wdata, 64'h4444_3333_2222_1111);
      serve(fesc_pkg::OP_ONCE_VERIFY, 1'b1, 1'b0, 64'h0);
      finish(1'b0, 1'b0, 1'b1, 1'b0);
      chk("read_invalid", inv, 1'b0);
      launch({16'h0, 16'h0, 16'h0, 16'h0, 16'h0005, 16'h0700}, 3'h5);
      serve(fesc_pkg::OP_ONCE_READ, 1'b0, 1'b0, 64'h0123_4567_89ab_cdef);
      finish(1'b1, 1'b0, 1'b0, 1'b0);
   endtask
   task automatic bad(input logic [15:0] s0, input logic [15:0] s1, input logic [2:0] i,
                      input logic [5:0] cfg, input logic a, input logic p);
      {backdoor_key_enable_field, avail, anyp, blkp, secp} <= cfg;
      launch({64'h0, s1, s0}, i);
      finish(a, p, 1'b0, 1'b0);
   endtask
   task automatic err_cases();
      bad(16'h0700, 16'h0008, 3'h5, 6'h28, 1'b1, 1'b0);
      bad(16'h0700, 16'h0002, 3'h4, 6'h28, 1'b1, 1'b0);
      bad(16'h0700, 16'h0002, 3'h5, 6'h20, 1'b1, 1'b0);
      bad(16'h0800, 16'h0000, 3'h1, 6'h28, 1'b1, 1'b0);
      bad(16'h0800, 16'h0000, 3'h0, 6'h2c, 1'b0, 1'b1);
      bad(16'h0b00, 16'h0000, 3'h0, 6'h2c, 1'b0, 1'b1);
      bad(16'h0b00, 16'h0000, 3'h1, 6'h28, 1'b1, 1'b0);
      bad(16'h0b00, 16'h0000, 3'h0, 6'h20, 1'b1, 1'b0);
      bad(16'h0903, 16'h0000, 3'h0, 6'h28, 1'b1, 1'b0);
      bad(16'h0901, 16'h0000, 3'h1, 6'h28, 1'b1, 1'b0);
      bad(16'h0903, 16'h0004, 3'h1, 6'h28, 1'b1, 1'b0);
      bad(16'h0900, 16'h0001, 3'h1, 6'h28, 1'b1, 1'b0);
      bad(16'h0903, 16'h0000, 3'h1, 6'h2a, 1'b0, 1'b1);
      bad(16'h0a03, 16'h0000, 3'h2, 6'h28, 1'b1, 1'b0);
      bad(16'h0a03, 16'h0003, 3'h1, 6'h28, 1'b1, 1'b0);
      bad(16'h0a02, 16'h0000, 3'h1, 6'h28, 1'b1, 1'b0);
      bad(16'h0a03, 16'h1238, 3'h1, 6'h29, 1'b0, 1'b1);
      bad(16'h0c00, 16'h0000, 3'h3, 6'h28, 1'b1, 1'b0);
      bad(16'h0c00, 16'h0000, 3'h4, 6'h18, 1'b1, 1'b0);
      {backdoor_key_enable_field, avail, anyp, blkp, secp} <= 6'h28;
   endtask
   task automatic ers(input logic [15:0] s0, input logic [15:0] s1, input logic [2:0] i, input logic [3:0] o1,
                      input logic [3:0] o2, input logic f, input logic n, input int xr);
      int r0;
      r0 = rel_cnt;
      launch({64'h0, s1, s0}, i);
      serve(o1, 1'b0, 1'b0, 64'h0);
      if (o1 != fesc_pkg::OP_ERASE_ALL) chk("erase_addr", addr, {s0[1:0], s1});
      serve(o2, f, n, 64'h0);
      finish(1'b0, 1'b0, f, n);
      chk("release_count", rel_cnt - r0, xr);
   endtask
   task automatic erase_cmds();
      ers(16'h0800, 16'h0, 3'h0, fesc_pkg::OP_ERASE_ALL, fesc_pkg::OP_VERIFY_ALL, 1'b0, 1'b0, 1);
      ers(16'h0b00, 16'h0, 3'h0, fesc_pkg::OP_ERASE_ALL, fesc_pkg::OP_VERIFY_ALL, 1'b1, 1'b1, 0);
      ers(16'h0b00, 16'h0, 3'h0, fesc_pkg::OP_ERASE_ALL, fesc_pkg::OP_VERIFY_ALL, 1'b0, 1'b0, 1);
      ers(16'h0903, 16'h8000, 3'h1, fesc_pkg::OP_ERASE_BLOCK, fesc_pkg::OP_VERIFY_BLOCK, 1'b0, 1'b0, 0);
      ers(16'h0900, 16'h0002, 3'h1, fesc_pkg::OP_ERASE_BLOCK, fesc_pkg::OP_VERIFY_BLOCK, 1'b1, 1'b0, 0);
      ers(16'h0a03, 16'h4560, 3'h1, fesc_pkg::OP_ERASE_SECTOR, fesc_pkg::OP_VERIFY_SECTOR, 1'b0, 1'b0, 0);
   endtask
   task automatic key_cmds();
      logic [95:0] kw;
      int r0;
      kw = {16'h0, 16'hd4d4, 16'hc3c3, 16'hb2b2, 16'ha1a1, 16'h0c00};
      r0 = rel_cnt;
      launch(kw, 3'h4);
      serve(fesc_pkg::OP_KEY_READ, 1'b0, 1'b0, 64'hd4d4_c3c3_b2b2_a1a1);
      chk("key_addr", addr, fesc_pkg::KEY_BASE_ADDR);
      finish(1'b0, 1'b0, 1'b0, 1'b0);
      chk("key_release", rel_cnt - r0, 1);
      launch(kw, 3'h4);
      serve(fesc_pkg::OP_KEY_READ, 1'b0, 1'b0, 64'hd4d4_c3c3_b2b2_a1a0);
      finish(1'b1, 1'b0, 1'b0, 1'b0);
      chk("lockout", lock, 1'b1);
      launch(kw, 3'h4);
      finish(1'b1, 1'b0, 1'b0, 1'b0);
      chk("key_release", rel_cnt - r0, 1);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk("lockout_after_reset", lock, 1'b0);
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (rel === 1'b1) rel_cnt++;
      if (cycles == 20000) begin
         err_count++;
         print_verdict();
      end
   end
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      chk("complete_in_reset", ccf, 1'b1);
      prog_once();
      err_cases();
      erase_cmds();
      key_cmds();
      print_verdict();
   end
endmodule
`default_nettype wire
